// File: apso_pkg.sv
`default_nettype none

package apso_pkg;
    // Result format
    localparam int CODE_W = 15;
    localparam int LEVEL_W = 16;
    localparam int WORD_W = CODE_W + 1;
    localparam int CODE_MSB = 14;
    localparam int CODE_LSB = 0;
    localparam logic signed [LEVEL_W:0] CODE_MAX = 17'sh03fff;
    localparam logic signed [LEVEL_W:0] CODE_MIN = -17'sh04000;

    // Pipeline and timing
    localparam int PIPE_LATENCY = 3;
    localparam real STROBE_DELAY_NS = 6.5;
    localparam real CLK_PERIOD_NS = 10.0;
    localparam int STROBE_DELAY_CYC = (STROBE_DELAY_NS / CLK_PERIOD_NS) > 1.0 ?
        int'(STROBE_DELAY_NS / CLK_PERIOD_NS + 0.999) : 1;

    // Reset values
    localparam logic [CODE_W-1:0] CODE_RST = 15'h0000;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [1:0] CNT_RST = 2'h0;

    // Tap buffer fill states
    typedef enum logic [1:0] {
        APSO_BUF_EMPTY = 2'b00,
        APSO_BUF_ONE = 2'b01,
        APSO_BUF_TWO = 2'b10
    } apso_buf_t;
endpackage : apso_pkg

`default_nettype wire

// File: apso_top.sv
// Functional notes
// - Sample the analog input on the rising edge of the differential sample clock.
// - Each result is a 15-bit two's-complement code on the parallel bus.
// - Bus bit 0 carries the LSB, bit 14 carries the sign bit.
// - Overrange flag high when input exceeds full scale, low when in range.
// - Valid strobe rises after each falling sample clock edge, 6.5 ns typical.
// - Result appears three sample clock cycles after its sampling edge.
// - Output data is stable at the rising edge of the valid strobe.
// - Overrange flag is timed exactly like the data bits of its sample.
`timescale 1ns/10ps
`default_nettype none

module apso_top
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic sample_clock_pos,
    input wire logic sample_clock_neg,
    input wire logic [apso_pkg::LEVEL_W-1:0] analog_in_pos,
    input wire logic [apso_pkg::LEVEL_W-1:0] analog_in_neg,
    output logic [apso_pkg::CODE_W-1:0] sample_code_bits_out,
    output logic overrange_flag_out,
    output logic sample_valid_strobe_out,
    output logic [apso_pkg::WORD_W-1:0] tap_word_out,
    output logic tap_valid_out,
    input wire logic tap_ready_in
);
    import apso_pkg::*;

    // Differential difference with clamping to the code range
    function automatic logic [WORD_W-1:0] apso_convert(input logic [LEVEL_W-1:0] pos,
                                                      input logic [LEVEL_W-1:0] neg);
        logic signed [LEVEL_W:0] diff;
        diff = $signed({1'b0, pos}) - $signed({1'b0, neg});
        if (diff > CODE_MAX)
            apso_convert = {1'b1, CODE_MAX[CODE_W-1:0]};
        else if (diff < CODE_MIN)
            apso_convert = {1'b1, CODE_MIN[CODE_W-1:0]};
        else
            apso_convert = {1'b0, diff[CODE_W-1:0]};
    endfunction : apso_convert

    // System reset release
    logic rst_sync1_reg;
    logic rst_n;
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_sync1_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_sync1_reg <= 1'b1;
            rst_n <= rst_sync1_reg;
        end
    end

    // Link reset release; the sample clock is free running
    logic lrst_sync1_reg;
    logic lrst_n;
    always_ff @(posedge sample_clock_pos or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            lrst_sync1_reg <= 1'b0;
            lrst_n <= 1'b0;
        end
        else
        begin
            lrst_sync1_reg <= 1'b1;
            lrst_n <= lrst_sync1_reg;
        end
    end

    // Only the rising edge of sample_clock_pos counts as the crossing; sample_clock_neg is not compared
    wire sample_clock_unused = sample_clock_neg;

    // Conversion pipeline; stage one is the sampling edge itself
    wire [WORD_W-1:0] conv_word = apso_convert(analog_in_pos, analog_in_neg);
    logic [WORD_W-1:0] pipe_reg [PIPE_LATENCY];
    logic [PIPE_LATENCY-1:0] pipe_vld_reg;
    logic [CODE_W-1:0] code_reg;
    logic ovr_reg;
    logic out_vld_reg;
    always_ff @(posedge sample_clock_pos or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            for (int i = 0; i < PIPE_LATENCY; i++)
                pipe_reg[i] <= WORD_RST;
            pipe_vld_reg <= '0;
            code_reg <= CODE_RST;
            ovr_reg <= 1'b0;
            out_vld_reg <= 1'b0;
        end
        else
        begin
            pipe_reg[0] <= conv_word;
            for (int i = 1; i < PIPE_LATENCY; i++)
                pipe_reg[i] <= pipe_reg[i-1];
            pipe_vld_reg <= {pipe_vld_reg[PIPE_LATENCY-2:0], 1'b1};
            // Flag and code leave the same stage on the same edge
            code_reg <= pipe_reg[PIPE_LATENCY-1][CODE_W-1:0];
            ovr_reg <= pipe_reg[PIPE_LATENCY-1][CODE_W];
            out_vld_reg <= pipe_vld_reg[PIPE_LATENCY-1];
        end
    end

    // Strobe: set on falling edge, cleared on rising edge, so data has half a period
    // to settle before the strobe rises; the pad driver adds the nanosecond delay
    logic stb_rise_reg;
    logic stb_fall_reg;
    always_ff @(negedge sample_clock_pos or negedge lrst_n)
    begin
        if (!lrst_n)
            stb_rise_reg <= 1'b0;
        else
            stb_rise_reg <= out_vld_reg ? ~stb_fall_reg : stb_fall_reg;
    end
    always_ff @(posedge sample_clock_pos or negedge lrst_n)
    begin
        if (!lrst_n)
            stb_fall_reg <= 1'b0;
        else
            stb_fall_reg <= stb_rise_reg;
    end

    assign sample_code_bits_out = code_reg;
    assign overrange_flag_out = ovr_reg;
    assign sample_valid_strobe_out = stb_rise_reg ^ stb_fall_reg;

    // Link side of the tap handshake; samples arriving while busy are skipped
    logic [WORD_W-1:0] xfer_word_reg;
    logic req_tog_reg;
    logic [2:0] ack_sync_reg;
    logic ack_seen_reg;
    logic ack_tog_reg; // Driven on the system side, declared here for the link synchroniser
    wire link_idle = (req_tog_reg == ack_seen_reg);
    always_ff @(posedge sample_clock_pos or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            ack_sync_reg <= 3'h0;
            ack_seen_reg <= 1'b0;
            xfer_word_reg <= WORD_RST;
            req_tog_reg <= 1'b0;
        end
        else
        begin
            ack_sync_reg <= {ack_sync_reg[1:0], ack_tog_reg};
            if (ack_sync_reg[2] == ack_sync_reg[1])
                ack_seen_reg <= ack_sync_reg[2];
            if (link_idle && out_vld_reg)
            begin
                xfer_word_reg <= {ovr_reg, code_reg};
                req_tog_reg <= ~req_tog_reg;
            end
        end
    end

    // System side: accept when the request settles and the buffer has room
    logic [2:0] req_sync_reg;
    wire req_pending = (req_sync_reg[2] == req_sync_reg[1]) && (req_sync_reg[2] != ack_tog_reg);
    wire buf_in_ready;
    wire buf_push = req_pending && buf_in_ready;
    always_ff @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_sync_reg <= 3'h0;
            ack_tog_reg <= 1'b0;
        end
        else
        begin
            req_sync_reg <= {req_sync_reg[1:0], req_tog_reg};
            if (buf_push)
                ack_tog_reg <= ~ack_tog_reg;
        end
    end

    // Two-entry buffer; a stalled reader holds the ack and so the link side
    logic [WORD_W-1:0] head_reg;
    logic [WORD_W-1:0] tail_reg;
    apso_buf_t fill_reg;
    logic vld_reg;
    wire buf_pop = vld_reg && tap_ready_in;
    assign buf_in_ready = (fill_reg != APSO_BUF_TWO);
    apso_buf_t fill_next;
    always_comb
    begin
        case (fill_reg)
            APSO_BUF_EMPTY: fill_next = buf_push ? APSO_BUF_ONE : APSO_BUF_EMPTY;
            APSO_BUF_ONE: fill_next = (buf_push && !buf_pop) ? APSO_BUF_TWO :
                                      (!buf_push && buf_pop) ? APSO_BUF_EMPTY : APSO_BUF_ONE;
            APSO_BUF_TWO: fill_next = buf_pop ? APSO_BUF_ONE : APSO_BUF_TWO;
            default: fill_next = APSO_BUF_EMPTY;
        endcase
    end
    always_ff @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            head_reg <= WORD_RST;
            tail_reg <= WORD_RST;
            fill_reg <= APSO_BUF_EMPTY;
            vld_reg <= 1'b0;
        end
        else
        begin
            fill_reg <= fill_next;
            vld_reg <= (fill_next != APSO_BUF_EMPTY);
            if (fill_reg == APSO_BUF_TWO && buf_pop)
                head_reg <= tail_reg;
            else if (buf_push && (fill_reg == APSO_BUF_EMPTY || buf_pop))
                head_reg <= xfer_word_reg;
            if (buf_push && fill_reg == APSO_BUF_ONE && !buf_pop)
                tail_reg <= xfer_word_reg;
        end
    end

    assign tap_word_out = head_reg;
    assign tap_valid_out = vld_reg;
endmodule : apso_top

`default_nettype wire

// File: apso_checker.sv
`timescale 1ns/10ps
`default_nettype none
module apso_checker
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic sample_clock_pos,
    input wire logic sample_clock_neg,
    input wire logic [15:0] analog_in_pos,
    input wire logic [15:0] analog_in_neg,
    input wire logic [14:0] sample_code_bits_out,
    input wire logic overrange_flag_out,
    input wire logic sample_valid_strobe_out,
    input wire logic [15:0] tap_word_out,
    input wire logic tap_valid_out,
    input wire logic tap_ready_in
);
    import apso_pkg::*;
    // Reference conversion of the input, clamped to the code range
    logic signed [16:0] diff;
    logic ovr;
    logic [14:0] code;
    assign diff = $signed({1'b0, analog_in_pos}) - $signed({1'b0, analog_in_neg});
    assign ovr = diff > CODE_MAX || diff < CODE_MIN;
    assign code = ovr ? (diff[16] ? 15'h4000 : 15'h3fff) : diff[14:0];
    sequence quiet_start;
        !sample_valid_strobe_out [*4];
    endsequence
    code_latency_a:
        assert property (@(posedge sample_clock_pos) disable iff (!arst_n_in)
        sample_valid_strobe_out |-> sample_code_bits_out == $past(code, 4)) else $error("bad code");
    flag_latency_a:
        assert property (@(posedge sample_clock_pos) disable iff (!arst_n_in)
        sample_valid_strobe_out |-> overrange_flag_out == $past(ovr, 4)) else $error("bad flag");
    strobe_steady_a:
        assert property (@(posedge sample_clock_pos) disable iff (!arst_n_in)
        sample_valid_strobe_out |=> sample_valid_strobe_out) else $error("strobe missing");
    strobe_low_a:
        assert property (@(negedge sample_clock_pos) disable iff (!arst_n_in)
        !sample_valid_strobe_out) else $error("strobe high before fall");
    no_early_strobe_a:
        assert property (@(posedge sample_clock_pos) disable iff (!arst_n_in)
        $rose(arst_n_in) |-> quiet_start) else $error("early strobe");
    data_stable_a:
        assert property (@(posedge clock_in) disable iff (!arst_n_in)
        sample_valid_strobe_out && $past(sample_valid_strobe_out)
        |-> $stable({overrange_flag_out, sample_code_bits_out})) else $error("data moved");
    flag_clamp_a:
        assert property (@(posedge clock_in) disable iff (!arst_n_in)
        overrange_flag_out |-> sample_code_bits_out inside {15'h3fff, 15'h4000})
        else $error("flag without clamp");
    tap_hold_a:
        assert property (@(posedge clock_in) disable iff (!arst_n_in)
        tap_valid_out && !tap_ready_in |=> tap_valid_out && $stable(tap_word_out))
        else $error("tap word lost");
endmodule : apso_checker
bind apso_top apso_checker u_chk (.*);
`default_nettype wire

// File: apso_capture.sv
`timescale 1ns/10ps
`default_nettype none
module apso_capture
(
    input wire logic strobe_in,
    input wire logic [14:0] code_in,
    input wire logic flag_in,
    output logic [15:0] word_out
);
    // Latch clocked by the valid strobe, code and flag as one word
    always_ff @(posedge strobe_in) word_out <= {flag_in, code_in};
endmodule : apso_capture
`default_nettype wire

// File: apso_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module apso_top_tb;
    logic clock_in = 1'b0;
    logic sample_clock_pos = 1'b0;
    logic sample_clock_neg;
    logic arst_n_in = 1'b0;
    logic tap_ready_in = 1'b1;
    logic [15:0] analog_in_pos = 16'h8000;
    logic [15:0] analog_in_neg = 16'h8000;
    logic [14:0] sample_code_bits_out;
    logic overrange_flag_out, sample_valid_strobe_out, tap_valid_out;
    logic [15:0] tap_word_out, cap_word;
    int err_count = 0;
    int checks_done = 0;
    // Inputs and expected {flag, code}, boundaries on both sides
    localparam logic [15:0] TV [7][3] = '{'{16'h8000, 16'h8000, 16'h0000},
        '{16'h3fff, 16'h0000, 16'h3fff}, '{16'h4000, 16'h0000, 16'hbfff},
        '{16'h0000, 16'h4000, 16'h4000}, '{16'h0000, 16'h0001, 16'h7fff},
        '{16'h0005, 16'h0002, 16'h0003}, '{16'h0000, 16'h4001, 16'hc000}};
    // Link clock offset so its edges never meet a rising edge of the system clock
    assign sample_clock_neg = ~sample_clock_pos;
    always #5 clock_in = ~clock_in;
    initial #2 forever #24 sample_clock_pos = ~sample_clock_pos;
    apso_top i_dut (.*);
    apso_capture i_cap (.strobe_in(sample_valid_strobe_out), .code_in(sample_code_bits_out),
        .flag_in(overrange_flag_out), .word_out(cap_word));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Hold an input long enough for latch and tap both to see it; seven rises
    // also cover the two-rise reset release ahead of the first sample
    task conv(input logic [15:0] p, input logic [15:0] n, input logic [15:0] w);
        logic hit;
        hit = 1'b0;
        @(posedge clock_in);
        analog_in_pos <= p;
        analog_in_neg <= n;
        repeat (7) @(posedge sample_clock_pos);
        #1;
        chk(cap_word, w);
        repeat (80) @(posedge clock_in)
            if (tap_valid_out === 1'b1 && tap_word_out === w) hit = 1'b1;
        chk({15'h0, hit}, 16'h0001);
    endtask : conv
    task t_codes;
        for (int i = 0; i < 7; i++) conv(TV[i][0], TV[i][1], TV[i][2]);
        $display("t_codes done");
    endtask : t_codes
    // Stalled tap keeps its head word while the input moves on
    task t_stall;
        @(posedge clock_in);
        tap_ready_in <= 1'b0;
        repeat (60) @(posedge clock_in);
        chk({15'h0, tap_valid_out}, 16'h0001);
        analog_in_pos <= 16'h0005;
        analog_in_neg <= 16'h0002;
        repeat (60) @(posedge clock_in);
        chk(tap_word_out, TV[6][2]);
        tap_ready_in <= 1'b1;
        conv(16'h0005, 16'h0002, 16'h0003);
        $display("t_stall done");
    endtask : t_stall
    task t_reset;
        @(posedge clock_in);
        arst_n_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        chk({overrange_flag_out, sample_code_bits_out}, 16'h0000);
        chk({15'h0, sample_valid_strobe_out}, 16'h0000);
        chk(tap_word_out, 16'h0000);
        chk({15'h0, tap_valid_out}, 16'h0000);
        repeat (4) @(posedge sample_clock_pos);
        @(posedge clock_in);
        arst_n_in <= 1'b1;
        conv(16'h8001, 16'h8000, 16'h0001);
        $display("t_reset done");
    endtask : t_reset
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    initial
    begin
        repeat (4) @(posedge sample_clock_pos);
        @(posedge clock_in);
        arst_n_in <= 1'b1;
        t_codes;
        t_stall;
        t_reset;
        end_sim;
    end
    // Watchdog far beyond the expected run length
    initial
    begin
        #100000;
        err_count++;
        end_sim;
    end
endmodule : apso_top_tb
`default_nettype wire
